/* File: hdl/imtc_pkg.sv */
// Behaviour
// - Programming mode may be entered only from charge mode.
// - A 5 s hold in charge mode enters programming, indicators green and yellow.
// - After release both indicators blink 1, 2 or 3 times for 50 ms, 1 s, 2 s.
// - Each short press in programming advances the transfer time cyclically.
// - A 5 s hold lights both solid; release returns to charge, keeping the choice.
// - Thirty idle blink cycles in programming return the unit to charge mode.
// - Charging starts only after every startup diagnostic has passed.
// - Float target 2.27 V/cell at 25 C, minus 4 mV/cell per degree.
// - Above 40 C no further compensation; the 40 C value is held.
// - Low-voltage cutoff is fixed at 20.1 V string, no compensation.
// - Inverter overload: pulse-by-pulse limit plus averaged check over seconds.
// - The always-on output is energised whenever the system is on.
// - In charge mode each switched output follows its command input.
// - In inverter mode every output is energised, commands ignored.
// - Automatic test every 28 days; day counter clears on any inverter entry.
// - A short press runs inverter mode at least 15 s, then returns when synced.
// - A 5 s hold during the monthly test starts a 90 minute yearly inverter test.
// - Transfer time defaults to 50 ms out of reset.
// - At cutoff the fault shows for 1 minute, then the unit switches off.
package imtc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned HOLD_S        = 5;
  localparam int unsigned HOLD_MS       = HOLD_S * 1000;
  localparam int unsigned MONTH_TEST_S  = 15;
  localparam int unsigned MONTH_TEST_MS = MONTH_TEST_S * 1000;
  localparam int unsigned YEAR_TEST_MIN = 90;
  localparam int unsigned YEAR_TEST_MS  = YEAR_TEST_MIN * 60000;
  localparam int unsigned LVD_SHOW_MIN  = 1;
  localparam int unsigned LVD_SHOW_MS   = LVD_SHOW_MIN * 60000;
  localparam int unsigned AUTO_DAYS     = 28;
  localparam logic [31:0] AUTO_TEST_MS  = 32'(64'(AUTO_DAYS) * 64'd86400000);
  localparam int unsigned AVG_OVL_MS    = 2000;
  localparam int unsigned BLINK_MS      = 250;
  localparam int unsigned BLINK_CYC_MS  = 3000;
  localparam logic [4:0]  IDLE_CYCLES   = 5'h1E;
  localparam int          CELLS         = 12;
  localparam int          FLOAT_MV_CELL = 2270;
  localparam int          COMP_MV_CELL  = 4;
  localparam int          TEMP_MID_C    = 25;
  localparam int          TEMP_CAP_C    = 40;
  localparam logic [15:0] LVD_MV        = 16'h4E84;
  localparam logic [1:0]  TSEL_50MS     = 2'h0;
  localparam logic [1:0]  TSEL_2S       = 2'h2;

  typedef enum logic [1:0] {COL_OFF, COL_GREEN, COL_YELLOW, COL_RED} imtc_colour_t;
  typedef enum logic [2:0] {ST_START, ST_CHARGE, ST_PROG, ST_INV, ST_LVD, ST_FAULT,
                            ST_OFF} imtc_mode_t;
  typedef enum logic [1:0] {TS_NONE, TS_MONTH, TS_YEAR} imtc_test_t;
endpackage

/* File: hdl/imtc_button.sv */
`timescale 1ns/1ps
module imtc_button #(
  parameter int unsigned HOLD_TICKS = imtc_pkg::HOLD_MS
) (
  input  wire logic clk,         // System clock.
  input  wire logic rst_b,       // Asynchronous reset, active low.
  input  wire logic tick,        // One-millisecond strobe.
  input  wire logic btn_raw,     // Test button pin, high while pressed.
  output logic      hold_pulse,  // Hold time reached.
  output logic      short_pulse, // Released before the hold time.
  output logic      rel_pulse    // Any debounced release.
);
  import imtc_pkg::*;
  logic        s1_reg, s2_reg, deb_reg, deb_next, held_reg, held_next;
  logic [4:0]  dcnt_reg, dcnt_next;
  logic [31:0] hcnt_reg, hcnt_next;
  logic        hold_next, short_next, rel_next;

  always_comb begin
    deb_next   = deb_reg;
    dcnt_next  = dcnt_reg;
    hcnt_next  = hcnt_reg;
    held_next  = held_reg;
    hold_next  = 1'b0;
    // A level must hold for the whole debounce window before it is believed.
    if (s2_reg == deb_reg) begin
      dcnt_next = 5'h00;
    end else if (tick) begin
      dcnt_next = dcnt_reg + 5'h01;
      if (dcnt_reg == 5'(DEBOUNCE_MS - 1)) begin
        deb_next  = s2_reg;
        dcnt_next = 5'h00;
      end
    end
    if (!deb_reg) begin
      hcnt_next = 32'h0;
      held_next = 1'b0;
    end else if (tick && !held_reg) begin
      hcnt_next = hcnt_reg + 32'h1;
      if (hcnt_next == HOLD_TICKS) begin
        held_next = 1'b1;
        hold_next = 1'b1;
      end
    end
    rel_next   = deb_reg && !deb_next;
    short_next = rel_next && !held_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg      <= 1'b0;
      s2_reg      <= 1'b0;
      deb_reg     <= 1'b0;
      dcnt_reg    <= 5'h00;
      hcnt_reg    <= 32'h0;
      held_reg    <= 1'b0;
      hold_pulse  <= 1'b0;
      short_pulse <= 1'b0;
      rel_pulse   <= 1'b0;
    end else begin
      s1_reg      <= btn_raw;
      s2_reg      <= s1_reg;
      deb_reg     <= deb_next;
      dcnt_reg    <= dcnt_next;
      hcnt_reg    <= hcnt_next;
      held_reg    <= held_next;
      hold_pulse  <= hold_next;
      short_pulse <= short_next;
      rel_pulse   <= rel_next;
    end
  end
endmodule

/* File: hdl/imtc_blink.sv */
`timescale 1ns/1ps
module imtc_blink (
  input  wire logic       clk,       // System clock.
  input  wire logic       rst_b,     // Asynchronous reset, active low.
  input  wire logic       tick,      // One-millisecond strobe.
  input  wire logic       run,       // Pattern runs while high.
  input  wire logic [1:0] sel,       // Transfer time code, 0 to 2.
  output logic            lit,       // Indicators on.
  output logic            cycle_done // End of one blink cycle.
);
  import imtc_pkg::*;
  logic [11:0] ph_reg, ph_next;
  logic        lit_next, done_next;
  logic [11:0] slot;

  always_comb begin
    ph_next   = ph_reg;
    done_next = 1'b0;
    slot      = 12'(ph_reg / 12'(BLINK_MS));
    if (!run) begin
      ph_next = 12'h000;
    end else if (tick) begin
      if (ph_reg == 12'(BLINK_CYC_MS - 1)) begin
        ph_next   = 12'h000;
        done_next = 1'b1;
      end else begin
        ph_next = ph_reg + 12'h001;
      end
    end
    // One to three lit slots, each followed by a dark slot, then a pause.
    lit_next = run && !slot[0] && (slot < 12'({sel, 1'b0} + 3'h2));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg     <= 12'h000;
      lit        <= 1'b0;
      cycle_done <= 1'b0;
    end else begin
      ph_reg     <= ph_next;
      lit        <= lit_next;
      cycle_done <= done_next;
    end
  end
endmodule

/* File: hdl/imtc_ctrl.sv */
`timescale 1ns/1ps
module imtc_ctrl #(
  parameter int unsigned TICK_CYC  = imtc_pkg::TICK_CYCLES,
  parameter int unsigned HOLD_T    = imtc_pkg::HOLD_MS,
  parameter int unsigned MONTH_T   = imtc_pkg::MONTH_TEST_MS,
  parameter int unsigned YEAR_T    = imtc_pkg::YEAR_TEST_MS,
  parameter int unsigned LVD_T     = imtc_pkg::LVD_SHOW_MS,
  parameter int unsigned OVL_T     = imtc_pkg::AVG_OVL_MS,
  parameter logic [31:0] AUTO_T    = imtc_pkg::AUTO_TEST_MS
) (
  input  wire logic                  clk,         // System clock, 100 MHz.
  input  wire logic                  rst_b,       // Asynchronous reset, active low.
  input  wire logic                  test_btn,    // Test button pin.
  input  wire logic                  utility_ok,  // Utility present pin.
  input  wire logic                  line_sync,   // Inverter locked to utility pin.
  input  wire logic [2:0]            cmd_in,      // Switch command pins.
  input  wire logic                  overcurrent, // Pulse current limit comparator.
  input  wire logic                  avg_ovl,     // Filtered current above limit.
  input  wire logic                  check_done,  // Startup diagnostics finished.
  input  wire logic                  check_pass,  // All diagnostics passed.
  input  wire logic [15:0]           battery_mv,  // Battery string voltage.
  input  wire logic signed [7:0]     temp_c,      // Battery temperature.
  output imtc_pkg::imtc_colour_t     charge_indicator,   // Charge LED colour.
  output imtc_pkg::imtc_colour_t     inverter_indicator, // Inverter LED colour.
  output logic                       always_on_out,      // Normally-on output.
  output logic [2:0]                 switched_out,       // Switched outputs.
  output logic                       charge_en,          // Charger running.
  output logic                       inverter_run,       // Inverter running.
  output logic                       pwm_inhibit,        // Gate cut this cycle.
  output logic [1:0]                 transfer_sel,       // Transfer time code.
  output logic [15:0]                float_target_mv,    // Float setpoint.
  output logic                       power_off           // Unit switched off.
);
  import imtc_pkg::*;

  logic [6:0]  s1_reg, s2_reg;
  logic        util_s, sync_s, oc_s, avg_s;
  logic [2:0]  cmd_s;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic        tick_reg, tick_next;
  logic        hold_p, short_p, rel_p, blink_lit, blink_done;

  imtc_mode_t   mode_reg, mode_next;
  imtc_test_t   test_reg, test_next;
  logic [1:0]   tsel_reg, tsel_next;
  logic         phold_reg, phold_next, pexit_reg, pexit_next;
  logic [4:0]   idle_reg, idle_next;
  logic [31:0]  tmr_reg, tmr_next, day_reg, day_next, ovl_reg, ovl_next;
  imtc_colour_t chg_next, inv_next;
  logic [2:0]   sw_next;
  logic [15:0]  float_next;
  int           tcomp;

  assign {util_s, sync_s, cmd_s, oc_s, avg_s} = s2_reg;

  // Pins are synchronised here; the pulse limit thus acts 30 ns after the edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 7'h00;
      s2_reg <= 7'h00;
    end else begin
      s1_reg <= {utility_ok, line_sync, cmd_in, overcurrent, avg_ovl};
      s2_reg <= s1_reg;
    end
  end

  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h1;
    if (tick_cnt_reg == TICK_CYC - 1) begin
      tick_cnt_next = 32'h0;
      tick_next     = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  imtc_button #(.HOLD_TICKS(HOLD_T)) u_button (
    .clk         (clk),
    .rst_b       (rst_b),
    .tick        (tick_reg),
    .btn_raw     (test_btn),
    .hold_pulse  (hold_p),
    .short_pulse (short_p),
    .rel_pulse   (rel_p)
  );

  imtc_blink u_blink (
    .clk        (clk),
    .rst_b      (rst_b),
    .tick       (tick_reg),
    .run        (mode_reg == ST_PROG && !phold_reg && !pexit_reg),
    .sel        (tsel_reg),
    .lit        (blink_lit),
    .cycle_done (blink_done)
  );

  always_comb begin
    mode_next  = mode_reg;
    test_next  = test_reg;
    tsel_next  = tsel_reg;
    phold_next = phold_reg;
    pexit_next = pexit_reg;
    idle_next  = idle_reg;
    tmr_next   = tick_reg ? tmr_reg + 32'h1 : tmr_reg;
    day_next   = tick_reg ? day_reg + 32'h1 : day_reg;
    ovl_next   = 32'h0;
    unique case (mode_reg)
      ST_START: begin
        day_next = 32'h0;
        if (check_done) begin
          mode_next = check_pass ? ST_CHARGE : ST_FAULT;
        end
      end
      ST_CHARGE: begin
        if (!util_s) begin
          mode_next = ST_INV;
          test_next = TS_NONE;
        end else if (hold_p) begin
          mode_next  = ST_PROG;
          phold_next = 1'b1;
          pexit_next = 1'b0;
          idle_next  = 5'h00;
        end else if (short_p) begin
          mode_next = ST_INV;
          test_next = TS_MONTH;
        end else if (day_reg >= AUTO_T) begin
          mode_next = ST_INV;
          test_next = TS_MONTH;
        end
        if (mode_next == ST_INV) begin
          tmr_next = 32'h0;
          day_next = 32'h0;
        end
      end
      ST_PROG: begin
        if (!util_s) begin
          mode_next = ST_INV;
          test_next = TS_NONE;
          tmr_next  = 32'h0;
          day_next  = 32'h0;
        end else if (phold_reg) begin
          phold_next = !rel_p;
        end else if (pexit_reg) begin
          if (rel_p) begin
            mode_next = ST_CHARGE;
          end
        end else if (hold_p) begin
          pexit_next = 1'b1;
        end else if (short_p) begin
          tsel_next = (tsel_reg == TSEL_2S) ? TSEL_50MS : tsel_reg + 2'h1;
          idle_next = 5'h00;
        end else if (blink_done) begin
          idle_next = idle_reg + 5'h01;
          if (idle_next == IDLE_CYCLES) begin
            mode_next = ST_CHARGE;
          end
        end
      end
      ST_INV: begin
        day_next = 32'h0;
        ovl_next = avg_s ? (tick_reg ? ovl_reg + 32'h1 : ovl_reg) : 32'h0;
        if (battery_mv <= LVD_MV) begin
          mode_next = ST_LVD;
          tmr_next  = 32'h0;
        end else if (ovl_reg >= OVL_T) begin
          mode_next = ST_FAULT;
        end else if (test_reg == TS_MONTH && hold_p) begin
          test_next = TS_YEAR;
          tmr_next  = 32'h0;
        end else if (util_s && sync_s) begin
          if (test_reg == TS_NONE
              || (test_reg == TS_MONTH && tmr_reg >= MONTH_T)
              || (test_reg == TS_YEAR && tmr_reg >= YEAR_T)) begin
            mode_next = ST_CHARGE;
            test_next = TS_NONE;
          end
        end
      end
      ST_LVD: begin
        if (tmr_reg >= LVD_T) begin
          mode_next = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (short_p) begin
          mode_next = ST_START;
        end
      end
      ST_OFF: begin
        tmr_next = tmr_reg;
      end
    endcase

    // Outputs are computed from the next state so they align with mode_reg.
    chg_next = COL_OFF;
    inv_next = COL_OFF;
    sw_next  = 3'h0;
    unique case (mode_next)
      ST_START, ST_OFF: begin
      end
      ST_CHARGE: begin
        chg_next = COL_GREEN;
        sw_next  = cmd_s;
      end
      ST_PROG: begin
        sw_next = cmd_s;
        if (phold_next || pexit_next || blink_lit) begin
          chg_next = COL_GREEN;
          inv_next = COL_YELLOW;
        end
      end
      ST_INV: begin
        inv_next = COL_YELLOW;
        sw_next  = 3'h7;
      end
      ST_LVD, ST_FAULT: begin
        chg_next = COL_RED;
        inv_next = COL_RED;
      end
    endcase

    // Compensation stops at the cap so hot batteries are not starved further.
    tcomp = (int'(temp_c) > TEMP_CAP_C) ? TEMP_CAP_C : int'(temp_c);
    float_next = 16'(CELLS * (FLOAT_MV_CELL - COMP_MV_CELL * (tcomp - TEMP_MID_C)));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg           <= ST_START;
      test_reg           <= TS_NONE;
      tsel_reg           <= TSEL_50MS;
      phold_reg          <= 1'b0;
      pexit_reg          <= 1'b0;
      idle_reg           <= 5'h00;
      tmr_reg            <= 32'h0;
      day_reg            <= 32'h0;
      ovl_reg            <= 32'h0;
      charge_indicator   <= COL_OFF;
      inverter_indicator <= COL_OFF;
      switched_out       <= 3'h0;
      always_on_out      <= 1'b1; // The normally-on feed stays on in reset and drops only in ST_OFF.
      charge_en          <= 1'b0;
      inverter_run       <= 1'b0;
      pwm_inhibit        <= 1'b0;
      power_off          <= 1'b0;
      float_target_mv    <= 16'h0000;
    end else begin
      mode_reg           <= mode_next;
      test_reg           <= test_next;
      tsel_reg           <= tsel_next;
      phold_reg          <= phold_next;
      pexit_reg          <= pexit_next;
      idle_reg           <= idle_next;
      tmr_reg            <= tmr_next;
      day_reg            <= day_next;
      ovl_reg            <= ovl_next;
      charge_indicator   <= chg_next;
      inverter_indicator <= inv_next;
      switched_out       <= sw_next;
      always_on_out      <= (mode_next != ST_OFF);
      charge_en          <= (mode_next == ST_CHARGE || mode_next == ST_PROG);
      inverter_run       <= (mode_next == ST_INV);
      pwm_inhibit        <= oc_s && (mode_next == ST_INV);
      power_off          <= (mode_next == ST_OFF);
      float_target_mv    <= float_next;
    end
  end

  assign transfer_sel = tsel_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  prog_entry_a: assert property ((mode_reg == ST_CHARGE && util_s && hold_p)
    |=> mode_reg == ST_PROG && charge_indicator == COL_GREEN)
    else $error("hold in charge mode did not enter programming");
  prog_source_a: assert property ($rose(mode_reg == ST_PROG)
    |-> $past(mode_reg) == ST_CHARGE)
    else $error("programming entered from a mode other than charge");
  tsel_step_a: assert property ((mode_reg == ST_PROG && util_s && !phold_reg && !pexit_reg
    && !hold_p && short_p) |=> tsel_reg == (($past(tsel_reg) == 2'h2) ? 2'h0
    : $past(tsel_reg) + 2'h1))
    else $error("short press did not advance transfer time");
  start_gate_a: assert property ((mode_reg == ST_START && !(check_done && check_pass))
    |=> mode_reg != ST_CHARGE)
    else $error("charging began without passed diagnostics");
  float_cap_a: assert property ((temp_c > 8'sd40) |=> float_target_mv == 16'h6798)
    else $error("float target not held above 40 C");
  always_on_a: assert property ((mode_reg != ST_OFF) |-> always_on_out)
    else $error("always-on output dropped while on");
  switch_chg_a: assert property ((mode_reg == ST_CHARGE)
    |-> switched_out == $past(cmd_s))
    else $error("switched outputs do not follow commands");
  switch_inv_a: assert property ((mode_reg == ST_INV) |-> switched_out == 3'h7)
    else $error("switched outputs off in inverter mode");
  day_clear_a: assert property ($rose(mode_reg == ST_INV) |-> day_reg == 32'h0)
    else $error("day counter not cleared on inverter entry");
  lvd_cut_a: assert property ((mode_reg == ST_INV && battery_mv <= LVD_MV)
    |=> mode_reg == ST_LVD ##1 charge_indicator == COL_RED)
    else $error("cutoff not taken at threshold");
  month_min_a: assert property (($fell(mode_reg == ST_INV) && mode_reg == ST_CHARGE
    && $past(test_reg) == TS_MONTH) |-> $past(tmr_reg) >= MONTH_T)
    else $error("monthly test ended early");

  prog_cov_c: cover property (mode_reg == ST_PROG && pexit_reg ##1 mode_reg == ST_CHARGE);
  year_cov_c: cover property (mode_reg == ST_INV && test_reg == TS_YEAR);
  off_cov_c:  cover property (mode_reg == ST_LVD ##1 mode_reg == ST_OFF);
  fault_cov_c: cover property (mode_reg == ST_FAULT ##1 mode_reg == ST_START);
endmodule

/* File: verif/imtc_panel_model.sv */
`timescale 1ns/1ps
module imtc_panel_model #(
  parameter int unsigned CHECK_CYC = 40,
  parameter int unsigned LOCK_CYC  = 60
) (
  input  wire logic clk,        // System clock.
  input  wire logic rst_b,      // Reset, active low.
  input  wire logic btn_down,   // Finger on the button.
  input  wire logic mains_on,   // Utility feed present.
  output logic      test_btn,   // Button contact.
  output logic      utility_ok, // Utility sense.
  output logic      line_sync,  // Inverter locked to utility.
  output logic      check_done, // Diagnostics finished.
  output logic      check_pass  // Diagnostics result.
);
  int unsigned boot_cnt;
  int unsigned lock_cnt;
  int unsigned bounce;
  logic        last_down;
  assign utility_ok = mains_on;
  assign check_pass = 1'b1;
  assign check_done = (boot_cnt >= CHECK_CYC);
  // Phase lock takes a while after the utility returns, so exits wait on a slow answer.
  assign line_sync  = mains_on && (lock_cnt >= LOCK_CYC);
  // Contacts chatter on every change, so the debouncer never sees a clean edge.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_cnt  <= 0;
      lock_cnt  <= 0;
      bounce    <= 0;
      last_down <= 1'b0;
      test_btn  <= 1'b0;
    end else begin
      if (boot_cnt < CHECK_CYC) boot_cnt <= boot_cnt + 1;
      lock_cnt  <= mains_on ? ((lock_cnt < LOCK_CYC) ? lock_cnt + 1 : lock_cnt) : 0;
      last_down <= btn_down;
      if (btn_down != last_down) bounce <= 6;
      else if (bounce != 0) bounce <= bounce - 1;
      test_btn  <= (bounce != 0) ? ~test_btn : btn_down;
    end
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import imtc_pkg::*;
  localparam int HOLD  = 40;
  localparam int MONTH = 100;
  localparam int YEAR  = 200;
  localparam int AUTO  = 300;
  localparam int LVDT  = 20;
  logic              clk;
  logic              rst_b;
  logic              btn_down;
  logic              mains_on;
  logic              test_btn;
  logic              utility_ok;
  logic              line_sync;
  logic              check_done;
  logic              check_pass;
  logic [2:0]        cmd_in;
  logic              overcurrent;
  logic              avg_ovl;
  logic [15:0]       battery_mv;
  logic signed [7:0] temp_c;
  imtc_colour_t      charge_indicator;
  imtc_colour_t      inverter_indicator;
  logic              always_on_out;
  logic [2:0]        switched_out;
  logic              charge_en;
  logic              inverter_run;
  logic              pwm_inhibit;
  logic [1:0]        transfer_sel;
  logic [15:0]       float_target_mv;
  logic              power_off;
  int                bad_count;
  int                comparisons;

  imtc_panel_model u_imtc_panel_model (.clk, .rst_b, .btn_down, .mains_on, .test_btn,
    .utility_ok, .line_sync, .check_done, .check_pass);
  imtc_ctrl #(.TICK_CYC(10), .HOLD_T(HOLD), .MONTH_T(MONTH), .YEAR_T(YEAR), .LVD_T(LVDT),
    .OVL_T(5), .AUTO_T(32'h0000012C)) u_imtc_ctrl (.clk, .rst_b, .test_btn, .utility_ok,
    .line_sync, .cmd_in, .overcurrent, .avg_ovl, .check_done, .check_pass,
    .battery_mv, .temp_c, .charge_indicator, .inverter_indicator, .always_on_out,
    .switched_out, .charge_en, .inverter_run, .pwm_inhibit, .transfer_sel,
    .float_target_mv, .power_off);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n * 10) @(negedge clk);
  endtask

  task automatic push(input int n);
    btn_down = 1'b1;
    ticks(n);
  endtask

  // The debounced release lands 20 ticks after the pin drops.
  task automatic lift;
    btn_down = 1'b0;
    ticks(25);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = inverter_run;
      1: pick = charge_en;
      default: pick = pwm_inhibit;
    endcase
  endfunction

  task automatic wait_on(input int s, input logic v, input int max);
    int i;
    for (i = 0; i < max && pick(s) !== v; i++) @(negedge clk);
    if (pick(s) !== v) begin
      bad_count++;
      $display("[ERR] wait %0d expected %0h seen timeout", s, v);
      stop_test();
    end
  endtask

  task automatic t_startup;
    @(negedge clk);
    `CHK("always_on", 1'b1, always_on_out)
    `CHK("charge_en", 1'b0, charge_en)
    wait_on(1, 1'b1, 100);
    `CHK("transfer_sel", TSEL_50MS, transfer_sel)
  endtask

  task automatic t_float;
    int tc[5] = '{25, 10, 40, 50, -5};
    int k;
    int e;
    for (k = 0; k < 5; k++) begin
      temp_c = 8'(tc[k]);
      e = 12 * (2270 - 4 * (((tc[k] > 40) ? 40 : tc[k]) - 25));
      repeat (3) @(negedge clk);
      `CHK("float", 16'(e), float_target_mv)
    end
    temp_c = 8'h19;
  endtask

  task automatic t_switch;
    int p;
    for (p = 0; p < 8; p++) begin
      cmd_in = 3'(p);
      ticks(1);
      `CHK("switched", 3'(p), switched_out)
    end
    cmd_in = 3'h0;
  endtask

  task automatic t_prog;
    int k;
    int rises;
    logic prev;
    logic cur;
    push(HOLD + 25);
    `CHK("chg_led", COL_GREEN, charge_indicator)
    `CHK("inv_led", COL_YELLOW, inverter_indicator)
    lift();
    push(25);
    lift();
    `CHK("sel", 2'h1, transfer_sel)
    rises = 0;
    prev = (charge_indicator !== COL_OFF);
    repeat (30000) begin
      @(negedge clk);
      cur = (charge_indicator !== COL_OFF);
      if (cur && !prev) rises++;
      prev = cur;
    end
    `CHK("blinks", 2, rises)
    for (k = 2; k < 5; k++) begin
      push(25);
      lift();
      `CHK("sel", 2'(k % 3), transfer_sel)
    end
    push(HOLD + 25);
    `CHK("chg_led", COL_GREEN, charge_indicator)
    `CHK("inv_led", COL_YELLOW, inverter_indicator)
    lift();
    `CHK("sel", 2'h1, transfer_sel)
    // The day count ran on while programming, so the overdue monthly test starts at once.
    wait_on(0, 1'b1, 20);
    wait_on(0, 1'b0, 1500);
  endtask

  // A short press from charge mode starts the monthly run; a hold during it starts the yearly run.
  task automatic t_tests;
    push(25);
    lift();
    wait_on(0, 1'b1, 10);
    `CHK("switched", 3'h7, switched_out)
    `CHK("always_on", 1'b1, always_on_out)
    ticks(MONTH - 40);
    `CHK("inverter", 1'b1, inverter_run)
    wait_on(0, 1'b0, 600);
    push(25);
    lift();
    push(HOLD + 25);
    lift();
    ticks(YEAR - 50);
    `CHK("inverter", 1'b1, inverter_run)
    wait_on(0, 1'b0, 800);
  endtask

  task automatic t_days;
    ticks(AUTO - 100);
    mains_on = 1'b0;
    wait_on(0, 1'b1, 50);
    mains_on = 1'b1;
    wait_on(0, 1'b0, 200);
    ticks(AUTO - 100);
    `CHK("inverter", 1'b0, inverter_run)
    wait_on(0, 1'b1, 1500);
    wait_on(0, 1'b0, 1500);
  endtask

  task automatic t_cutoff;
    mains_on = 1'b0;
    wait_on(0, 1'b1, 50);
    push(HOLD + 25);
    `CHK("charge_en", 1'b0, charge_en)
    lift();
    overcurrent = 1'b1;
    wait_on(2, 1'b1, 8);
    overcurrent = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("pwm_inhibit", 1'b0, pwm_inhibit)
    // A surge shorter than the averaging window must not trip the unit.
    avg_ovl = 1'b1;
    ticks(3);
    avg_ovl = 1'b0;
    ticks(1);
    `CHK("inverter", 1'b1, inverter_run)
    avg_ovl = 1'b1;
    ticks(8);
    `CHK("inverter", 1'b0, inverter_run)
    `CHK("inv_led", COL_RED, inverter_indicator)
    avg_ovl = 1'b0;
    push(25);
    lift();
    wait_on(0, 1'b1, 100);
    battery_mv = 16'h4E85;
    ticks(1);
    `CHK("inverter", 1'b1, inverter_run)
    battery_mv = 16'h4E84;
    repeat (4) @(negedge clk);
    `CHK("inv_led", COL_RED, inverter_indicator)
    ticks(LVDT - 5);
    `CHK("power_off", 1'b0, power_off)
    ticks(10);
    `CHK("power_off", 1'b1, power_off)
    `CHK("always_on", 1'b0, always_on_out)
  endtask

  initial begin
    rst_b = 1'b0;
    btn_down = 1'b0;
    mains_on = 1'b1;
    cmd_in = 3'h0;
    overcurrent = 1'b0;
    avg_ovl = 1'b0;
    battery_mv = 16'h6590;
    temp_c = 8'h19;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_startup();
    t_float();
    t_switch();
    t_prog();
    t_tests();
    t_days();
    t_cutoff();
    stop_test();
  end
endmodule
